//--- src/ascr_pkg.sv
// Constants and carrier types for the converter configuration register bank.
// Assumes a serial port front end that delivers byte-wide register accesses.
package ascr_pkg;
	localparam int ASCR_AW = 16;
	localparam int ASCR_DW = 8;
	localparam logic [15:0] ASCR_ADDR_PORT_CFG = 16'h0000;
	localparam logic [15:0] ASCR_ADDR_IDENT = 16'h0001;
	localparam logic [15:0] ASCR_ADDR_GRADE = 16'h0002;
	localparam logic [15:0] ASCR_ADDR_CHSEL = 16'h0005;
	localparam logic [15:0] ASCR_ADDR_POWER = 16'h0008;
	localparam logic [15:0] ASCR_ADDR_STAB = 16'h0009;
	localparam logic [15:0] ASCR_ADDR_CLKDIV = 16'h000b;
	localparam logic [15:0] ASCR_ADDR_XFER = 16'h00ff;
	localparam logic [7:0] ASCR_RST_PORT_CFG = 8'h18;
	localparam logic [7:0] ASCR_RST_CHSEL = 8'h3f;
	localparam logic [7:0] ASCR_RST_POWER = 8'h00;
	localparam logic [7:0] ASCR_RST_STAB = 8'h01;
	localparam logic [7:0] ASCR_RST_CLKDIV = 8'h00;
	localparam logic [7:0] ASCR_RST_XFER = 8'h00;
	localparam int ASCR_CFG_LSB_FIRST = 6;
	localparam int ASCR_CFG_SOFT_RESET = 5;
	localparam int ASCR_PWR_PIN_FUNC = 5;
	localparam int ASCR_XFER_INIT = 0;
	localparam int ASCR_NUM_TARGETS = 6;
	localparam int ASCR_CH_A = 0;
	localparam logic [2:0] ASCR_GRADE_80 = 3'h0;
	localparam logic [2:0] ASCR_GRADE_105 = 3'h1;
	localparam logic [2:0] ASCR_GRADE_125 = 3'h2;
	localparam logic [1:0] ASCR_PM_RUN = 2'h0;
	localparam logic [1:0] ASCR_PM_FULL_DOWN = 2'h1;
	localparam logic [1:0] ASCR_PM_STANDBY = 2'h2;
	localparam logic [1:0] ASCR_PM_DIG_RESET = 2'h3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ascr_req_s;

	typedef struct packed {
		logic [1:0] power_mode;
		logic pin_standby;
		logic stabilizer_en;
		logic [2:0] clk_div;
		logic lsb_first;
	} ascr_cfg_s;
endpackage

//--- src/ascr_regs.sv
// Configuration register bank of a quad converter: port config, identity,
// channel select, transfer trigger, power, stabilizer, clock divider.
// Assumes the serial front end on clk_sys presents one-cycle rd/wr strobes.
// How it works
// - Port config bits 0,7 zero; 3,4 one
// - Setting bit 5 soft-resets all user registers
// - Soft reset indication clears itself afterwards
// - Config nibbles mirrored; default 0x18
// - Read-only eight-bit identification at address one
// - Read-only speed grade field bits six-four
// - Channel select only drives outputs; local register writes land regardless
// - All six select bits set after reset
// - Transfer bit 0 applies the staged clock divider and pulses override
// - Power mode field selects operating state
// - Bit 5 picks pin's power-down or standby
// - Clock register bit 0 enables stabilizer
// - Clock divide field divides by value+1
// - Local reads ignore channel select
`timescale 1ns/10ps
module ascr_regs
	import ascr_pkg::*;
#(
	parameter logic [7:0] IDENT_CODE = 8'h5a, // Arbitrary value
	parameter logic [2:0] SPEED_GRADE = ASCR_GRADE_125
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire ascr_req_s req,
	input wire logic external_sleep_pin,
	output logic [7:0] rdata,
	output logic rvalid,
	output ascr_cfg_s cfg_active,
	output logic [ASCR_NUM_TARGETS-1:0] channel_select,
	output logic override_pulse,
	output logic [1:0] effective_power,
	output logic local_wr_mask_valid
);
	logic [7:0] port_cfg_reg;
	logic [7:0] chsel_reg;
	logic [7:0] power_reg;
	logic [7:0] stab_reg;
	logic [7:0] clkdiv_reg;
	logic [7:0] xfer_reg;
	logic soft_rst_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic [2:0] clkdiv_active_reg;
	logic override_reg;
	logic [1:0] eff_pwr_reg;
	logic [2:0] pin_sync_reg;
	logic pin_level_reg;
	logic [7:0] rdata_next;
	logic [7:0] cfg_wr_val;
	logic wr_cfg;
	logic wr_chsel;
	logic wr_power;
	logic wr_stab;
	logic wr_clkdiv;
	logic wr_xfer;
	logic hit;
	logic [1:0] eff_pwr_next;
	logic init_req;

	// Mirror one nibble onto the other
	function automatic logic [7:0] mirror_cfg(input logic [7:0] d);
		logic lsbf;
		logic srst;
		lsbf = d[6] | d[1];
		srst = d[5] | d[2];
		mirror_cfg = {1'b0, lsbf, srst, 1'b1, 1'b1, srst, lsbf, 1'b0};
	endfunction

	assign wr_cfg = req.wr && req.addr == ASCR_ADDR_PORT_CFG;
	assign wr_chsel = req.wr && req.addr == ASCR_ADDR_CHSEL;
	assign wr_power = req.wr && req.addr == ASCR_ADDR_POWER;
	assign wr_stab = req.wr && req.addr == ASCR_ADDR_STAB;
	assign wr_clkdiv = req.wr && req.addr == ASCR_ADDR_CLKDIV;
	assign wr_xfer = req.wr && req.addr == ASCR_ADDR_XFER;
	assign init_req = wr_xfer && req.wdata[ASCR_XFER_INIT];
	assign cfg_wr_val = mirror_cfg(req.wdata);
	// Identity and grade offsets have no write decode, so writes fall away
	assign hit = req.addr == ASCR_ADDR_IDENT || req.addr == ASCR_ADDR_GRADE;

	// Global registers ignore channel select; no local register here reads a copy
	assign rdata_next =
		(req.addr == ASCR_ADDR_PORT_CFG) ? port_cfg_reg :
		(req.addr == ASCR_ADDR_IDENT) ? IDENT_CODE :
		(req.addr == ASCR_ADDR_GRADE) ? {1'b0, SPEED_GRADE, 4'h0} :
		(req.addr == ASCR_ADDR_CHSEL) ? chsel_reg :
		(req.addr == ASCR_ADDR_POWER) ? power_reg :
		(req.addr == ASCR_ADDR_STAB) ? stab_reg :
		(req.addr == ASCR_ADDR_CLKDIV) ? clkdiv_reg :
		(req.addr == ASCR_ADDR_XFER) ? xfer_reg : 8'h00;

	// External pin modes: bit 5 chooses standby or full power-down
	assign eff_pwr_next = (power_reg[1:0] != ASCR_PM_RUN) ? power_reg[1:0] :
		!pin_level_reg ? ASCR_PM_RUN :
		power_reg[ASCR_PWR_PIN_FUNC] ? ASCR_PM_STANDBY : ASCR_PM_FULL_DOWN;

	// Pin synchroniser: change accepted when stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pin_sync_reg <= 3'h0;
			pin_level_reg <= 1'b0;
		end
		else
		begin
			pin_sync_reg <= {pin_sync_reg[1:0], external_sleep_pin};
			if (pin_sync_reg[2] == pin_sync_reg[1])
				pin_level_reg <= pin_sync_reg[2];
		end
	end

	// Soft reset takes one cycle, then reads back cleared
	always_ff @(posedge clk_sys)
	begin
		if (reset || soft_rst_reg)
		begin
			port_cfg_reg <= ASCR_RST_PORT_CFG;
			chsel_reg <= ASCR_RST_CHSEL;
			power_reg <= ASCR_RST_POWER;
			stab_reg <= ASCR_RST_STAB;
			clkdiv_reg <= ASCR_RST_CLKDIV;
			xfer_reg <= ASCR_RST_XFER;
			clkdiv_active_reg <= ASCR_RST_CLKDIV[2:0];
			override_reg <= 1'b0;
		end
		else
		begin
			override_reg <= 1'b0;
			if (wr_cfg)
				port_cfg_reg <= cfg_wr_val;
			if (wr_chsel)
				chsel_reg <= {2'h0, req.wdata[5:0]};
			if (wr_power)
				power_reg <= {2'h0, req.wdata[5], 3'h0, req.wdata[1:0]};
			if (wr_stab)
				stab_reg <= {7'h0, req.wdata[0]};
			if (wr_clkdiv)
				clkdiv_reg <= {5'h0, req.wdata[2:0]};
			if (init_req)
			begin
				clkdiv_active_reg <= clkdiv_reg[2:0];
				override_reg <= 1'b1;
			end
			xfer_reg <= 8'h00;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			soft_rst_reg <= 1'b0;
		else
			soft_rst_reg <= wr_cfg && cfg_wr_val[ASCR_CFG_SOFT_RESET] && !soft_rst_reg;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			eff_pwr_reg <= ASCR_PM_RUN;
		end
		else
		begin
			rdata_reg <= req.rd ? rdata_next : rdata_reg;
			rvalid_reg <= req.rd;
			eff_pwr_reg <= eff_pwr_next;
		end
	end

	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign channel_select = chsel_reg[ASCR_NUM_TARGETS-1:0];
	assign override_pulse = override_reg;
	assign effective_power = eff_pwr_reg;
	assign local_wr_mask_valid = chsel_reg[ASCR_CH_A];
	assign cfg_active = '{
		power_mode: power_reg[1:0],
		pin_standby: power_reg[ASCR_PWR_PIN_FUNC],
		stabilizer_en: stab_reg[0],
		clk_div: clkdiv_active_reg,
		lsb_first: port_cfg_reg[ASCR_CFG_LSB_FIRST]
	};

	property p_cfg_fixed;
		@(posedge clk_sys) disable iff (reset)
		!port_cfg_reg[0] && !port_cfg_reg[7] && port_cfg_reg[3] && port_cfg_reg[4];
	endproperty
	a_cfg_fixed: assert property (p_cfg_fixed) else $error("port config fixed bits wrong");

	sequence s_soft_req;
		wr_cfg && cfg_wr_val[ASCR_CFG_SOFT_RESET] && !soft_rst_reg;
	endsequence

	sequence s_soft_done;
		##1 soft_rst_reg ##1 (port_cfg_reg == ASCR_RST_PORT_CFG &&
			chsel_reg == ASCR_RST_CHSEL && stab_reg == ASCR_RST_STAB);
	endsequence

	sequence s_init_req;
		init_req && !soft_rst_reg;
	endsequence

	property p_soft_reset;
		@(posedge clk_sys) disable iff (reset)
		s_soft_req |-> s_soft_done;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

	property p_soft_all;
		@(posedge clk_sys) disable iff (reset)
		s_soft_req |-> ##2 (power_reg == ASCR_RST_POWER && clkdiv_reg == ASCR_RST_CLKDIV &&
			clkdiv_active_reg == ASCR_RST_CLKDIV[2:0]);
	endproperty
	a_soft_all: assert property (p_soft_all) else $error("soft reset left a register");

	property p_self_clear;
		@(posedge clk_sys) disable iff (reset)
		soft_rst_reg |=> !port_cfg_reg[2] && !soft_rst_reg;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("soft reset not cleared");

	property p_mirror;
		@(posedge clk_sys) disable iff (reset)
		port_cfg_reg[6] == port_cfg_reg[1] && port_cfg_reg[5] == port_cfg_reg[2];
	endproperty
	a_mirror: assert property (p_mirror) else $error("nibbles not mirrored");

	property p_ident;
		@(posedge clk_sys) disable iff (reset)
		req.rd && req.addr == ASCR_ADDR_IDENT |=> rvalid && rdata == IDENT_CODE;
	endproperty
	a_ident: assert property (p_ident) else $error("identity read wrong");

	property p_xfer;
		@(posedge clk_sys) disable iff (reset)
		s_init_req |=> override_pulse && cfg_active.clk_div == $past(clkdiv_reg[2:0]);
	endproperty
	a_xfer: assert property (p_xfer) else $error("override pulse wrong");

	property p_pulse_once;
		@(posedge clk_sys) disable iff (reset)
		override_pulse && !init_req |=> !override_pulse;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("override pulse too long");

	property p_xfer_clear;
		@(posedge clk_sys) disable iff (reset)
		req.rd && req.addr == ASCR_ADDR_XFER |=> rvalid && rdata == ASCR_RST_XFER;
	endproperty
	a_xfer_clear: assert property (p_xfer_clear) else $error("initiate not cleared");

	property p_pin_func;
		@(posedge clk_sys) disable iff (reset)
		power_reg[1:0] == ASCR_PM_RUN && pin_level_reg && power_reg[ASCR_PWR_PIN_FUNC] |=>
			effective_power == ASCR_PM_STANDBY;
	endproperty
	a_pin_func: assert property (p_pin_func) else $error("pin standby wrong");

	property p_pin_full;
		@(posedge clk_sys) disable iff (reset)
		power_reg[1:0] == ASCR_PM_RUN && pin_level_reg && !power_reg[ASCR_PWR_PIN_FUNC] |=>
			effective_power == ASCR_PM_FULL_DOWN;
	endproperty
	a_pin_full: assert property (p_pin_full) else $error("pin power-down wrong");

	property p_pin_idle;
		@(posedge clk_sys) disable iff (reset)
		power_reg[1:0] == ASCR_PM_RUN && !pin_level_reg |=> effective_power == ASCR_PM_RUN;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("run mode lost");

	property p_power_mode;
		@(posedge clk_sys) disable iff (reset)
		power_reg[1:0] != ASCR_PM_RUN |=> effective_power == $past(power_reg[1:0]);
	endproperty
	a_power_mode: assert property (p_power_mode) else $error("power mode not applied");

	property p_power_wr;
		@(posedge clk_sys) disable iff (reset)
		wr_power && !soft_rst_reg |=> power_reg[1:0] == $past(req.wdata[1:0]) &&
			power_reg[ASCR_PWR_PIN_FUNC] == $past(req.wdata[ASCR_PWR_PIN_FUNC]);
	endproperty
	a_power_wr: assert property (p_power_wr) else $error("power write lost");

	property p_grade;
		@(posedge clk_sys) disable iff (reset)
		req.rd && req.addr == ASCR_ADDR_GRADE |=> rvalid && rdata == {1'b0, SPEED_GRADE, 4'h0};
	endproperty
	a_grade: assert property (p_grade) else $error("speed grade read wrong");

	property p_ro_ignore;
		@(posedge clk_sys) disable iff (reset)
		req.wr && hit && !soft_rst_reg |=>
			$stable({port_cfg_reg, chsel_reg, power_reg, stab_reg, clkdiv_reg, clkdiv_active_reg});
	endproperty
	a_ro_ignore: assert property (p_ro_ignore) else $error("read-only write landed");

	property p_chsel_wr;
		@(posedge clk_sys) disable iff (reset)
		wr_chsel && !soft_rst_reg |=> chsel_reg == {2'h0, $past(req.wdata[5:0])};
	endproperty
	a_chsel_wr: assert property (p_chsel_wr) else $error("channel select write lost");

	property p_chsel_default;
		@(posedge clk_sys) disable iff (reset)
		soft_rst_reg |=> chsel_reg == ASCR_RST_CHSEL;
	endproperty
	a_chsel_default: assert property (p_chsel_default) else $error("select not all set");

	property p_stab;
		@(posedge clk_sys) disable iff (reset)
		wr_stab && !soft_rst_reg |=> cfg_active.stabilizer_en == $past(req.wdata[0]);
	endproperty
	a_stab: assert property (p_stab) else $error("stabilizer enable wrong");

	property p_clkdiv_wr;
		@(posedge clk_sys) disable iff (reset)
		wr_clkdiv && !soft_rst_reg |=> clkdiv_reg == {5'h0, $past(req.wdata[2:0])};
	endproperty
	a_clkdiv_wr: assert property (p_clkdiv_wr) else $error("divider staging wrong");

	property p_div_staged;
		@(posedge clk_sys) disable iff (reset)
		!init_req && !soft_rst_reg |=> $stable(cfg_active.clk_div);
	endproperty
	a_div_staged: assert property (p_div_staged) else $error("divider changed early");

	property p_lsb;
		@(posedge clk_sys) disable iff (reset)
		wr_cfg && !soft_rst_reg |=> cfg_active.lsb_first == $past(req.wdata[6] | req.wdata[1]);
	endproperty
	a_lsb: assert property (p_lsb) else $error("bit order not mirrored");

	property p_rvalid;
		@(posedge clk_sys) disable iff (reset)
		req.rd |=> rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");

	property p_rvalid_idle;
		@(posedge clk_sys) disable iff (reset)
		!req.rd |=> !rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");
endmodule // ascr_regs

//--- verification/ascr_host.sv
// Controller model: issues byte-wide register accesses to the bank.
// Assumes the bank answers a read with rvalid one cycle after it.
`timescale 1ns/10ps
module ascr_host
	import ascr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output ascr_req_s req
);
	initial req = '0;
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
	begin
		@(posedge clk_sys);
		req <= {1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		req <= {1'b0, 1'b0, ~a, ~d};
	end
	endtask
	task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
	begin
		@(posedge clk_sys);
		req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		req <= {1'b0, 1'b0, ~a, 8'hff};
		#1;
		d = rvalid ? rdata : 8'hxx;
	end
	endtask
endmodule // ascr_host

//--- verification/tb_top.sv
// Bench for the register bank, driven through the controller model.
// Assumes a 25 MHz clock and synchronous active-high reset.
`timescale 1ns/10ps
module tb_top
	import ascr_pkg::*;
;
	logic clk_sys;
	logic reset;
	logic external_sleep_pin;
	ascr_req_s req;
	logic [7:0] rdata;
	logic rvalid;
	ascr_cfg_s cfg_active;
	logic [5:0] channel_select;
	logic override_pulse;
	logic [1:0] effective_power;
	logic local_wr_mask_valid;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] v;
	logic [15:0] ad [9] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h8, 16'h9, 16'hb, 16'hff, 16'h13};
	logic [7:0] dv [9] = '{8'h18, 8'h5a, 8'h20, 8'h3f, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	ascr_regs i_ascr_regs (.clk_sys(clk_sys), .reset(reset), .req(req),
		.external_sleep_pin(external_sleep_pin), .rdata(rdata), .rvalid(rvalid),
		.cfg_active(cfg_active), .channel_select(channel_select),
		.override_pulse(override_pulse), .effective_power(effective_power),
		.local_wr_mask_valid(local_wr_mask_valid));
	ascr_host i_ascr_host (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid), .req(req));
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
	begin
		i_ascr_host.bus_rd(a, v);
		chk("rdata", e, v);
	end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
	begin
		i_ascr_host.bus_wr(a, d);
		#1;
	end
	endtask
	task automatic summarize;
	begin
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task automatic t_defaults;
	begin
		for (int i = 0; i < 9; i++)
			rchk(ad[i], dv[i]);
		$display("defaults done");
	end
	endtask
	task automatic t_cfg_ro;
	begin
		wr(ASCR_ADDR_PORT_CFG, 8'h42);
		rchk(ASCR_ADDR_PORT_CFG, 8'h5a);
		chk("lsb_first", 8'h01, {7'h0, cfg_active.lsb_first});
		wr(ASCR_ADDR_PORT_CFG, 8'h81);
		rchk(ASCR_ADDR_PORT_CFG, 8'h18);
		wr(ASCR_ADDR_IDENT, 8'hff);
		wr(ASCR_ADDR_GRADE, 8'hff);
		rchk(ASCR_ADDR_IDENT, 8'h5a);
		rchk(ASCR_ADDR_GRADE, 8'h20);
		$display("cfg and read-only done");
	end
	endtask
	task automatic t_chsel;
	begin
		wr(ASCR_ADDR_CHSEL, 8'h01);
		chk("chsel", 8'h01, {2'h0, channel_select});
		chk("mask", 8'h01, {7'h0, local_wr_mask_valid});
		wr(ASCR_ADDR_CHSEL, 8'h3e);
		chk("mask", 8'h00, {7'h0, local_wr_mask_valid});
		wr(ASCR_ADDR_STAB, 8'h00);
		chk("stab", 8'h00, {7'h0, cfg_active.stabilizer_en});
		$display("chsel done");
	end
	endtask
	task automatic t_power;
	begin
		for (int m = 0; m < 4; m++)
		begin
			wr(ASCR_ADDR_POWER, m[7:0]);
			chk("mode", m[7:0], {6'h0, cfg_active.power_mode});
			@(posedge clk_sys);
			#1;
			chk("eff", m[7:0], {6'h0, effective_power});
		end
		wr(ASCR_ADDR_POWER, 8'h20);
		chk("pin_standby", 8'h01, {7'h0, cfg_active.pin_standby});
		@(posedge clk_sys);
		external_sleep_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("eff", {6'h0, ASCR_PM_STANDBY}, {6'h0, effective_power});
		wr(ASCR_ADDR_POWER, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("eff", {6'h0, ASCR_PM_FULL_DOWN}, {6'h0, effective_power});
		@(posedge clk_sys);
		external_sleep_pin <= 1'b0;
		$display("power done");
	end
	endtask
	task automatic t_xfer;
	begin
		wr(ASCR_ADDR_CLKDIV, 8'h07);
		chk("div", 8'h00, {5'h0, cfg_active.clk_div});
		wr(ASCR_ADDR_XFER, 8'h01);
		chk("pulse", 8'h01, {7'h0, override_pulse});
		chk("div", 8'h07, {5'h0, cfg_active.clk_div});
		@(posedge clk_sys);
		#1;
		chk("pulse", 8'h00, {7'h0, override_pulse});
		rchk(ASCR_ADDR_XFER, 8'h00);
		$display("transfer done");
	end
	endtask
	task automatic t_soft;
	begin
		wr(ASCR_ADDR_POWER, 8'h02);
		wr(ASCR_ADDR_PORT_CFG, 8'h24);
		repeat (2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++)
			rchk(ad[i], dv[i]);
		chk("div", 8'h00, {5'h0, cfg_active.clk_div});
		$display("soft reset done");
	end
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			summarize();
		end
	end
	initial
	begin
		reset = 1'b1;
		external_sleep_pin = 1'b0;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_defaults();
		t_cfg_ro();
		t_chsel();
		t_power();
		t_xfer();
		t_soft();
		summarize();
	end
endmodule // tb_top
